// *** core/glitchless_clock_mux_network.sv ***
// Global clock network: pins, switch matrix lines and 24 select buffers.
// Assumes clk samples every clock far faster than its fastest phase.
// Assumes line_src, buf_mode and pin_manager_feed move only while quiet.
//
// Operation
// - Select 0 picks first input, 1 second.
// - Source change never glitches the output.
// - Output phases no shorter than input phases.
// - Inputs may be fully unrelated clocks.
// - Plain driver forwards one clock, no select.
// - Enabled driver gates clock through select logic.
// - Top and bottom buffers reach all quadrants.
// - Left and right buffers reach own half.
// - Paired buffers share inputs, crossed over.
// - Inputs from pins, managers or interconnect.
// - Half-edge matrix: pin, interconnect, present manager.
// - 16 global, 8 left, 8 right pins.
// - Pins feed managers or fabric as user pins.
`timescale 1ns/1ps
`default_nettype none
`include "clock_network_map.svh"
module glitchless_clock_mux_network
	import clock_network_pkg::*;
#(
	parameter logic LR_MANAGER_PRESENT = 1'b1 // Managers on left and right edges
) (
	input  wire logic                      clk,                    // Sampling clock
	input  wire logic                      srst,                   // Sync reset, high
	input  wire logic [`NUM_GLOBAL_PINS-1:0] global_clock_pin,     // Top/bottom pins
	input  wire logic [`NUM_HALF_PINS-1:0] left_half_clock_pin,    // Left edge pins
	input  wire logic [`NUM_HALF_PINS-1:0] right_half_clock_pin,   // Right edge pins
	input  wire logic [`NUM_BUFS-1:0]      clock_manager_tile_clk, // Manager per line
	input  wire logic [`NUM_BUFS-1:0]      fabric_clk,             // Double-line per line
	input  wire logic [`NUM_BUFS-1:0]      buf_select,             // Select per buffer
	input  wire logic [`NUM_BUFS-1:0]      buf_enable,             // Enable per buffer
	input  wire src_sel_t                  line_src [`NUM_BUFS],   // Line source choice
	input  wire buf_mode_t                 buf_mode [`NUM_BUFS],   // Buffer flavour
	input  wire logic [31:0]               pin_manager_feed,       // Pin to manager path
	output logic [`NUM_QUADS-1:0][`QUAD_WIDTH-1:0] quad_clk_r,     // Quadrant clocks
	output logic [`NUM_BUFS-1:0]           buf_clk_r,              // Buffer outputs
	output logic [`NUM_BUFS-1:0]           buf_source_r,           // Live source
	output logic [31:0]                    pin_user_r,             // Pins as user inputs
	output logic [31:0]                    pin_manager_r           // Pins to managers
);

	// Layout of the synchronised vector
	// Offsets follow raw_in, lowest field first
	localparam int G_LO   = 0;
	localparam int L_LO   = G_LO + `NUM_GLOBAL_PINS;
	localparam int R_LO   = L_LO + `NUM_HALF_PINS;
	localparam int M_LO   = R_LO + `NUM_HALF_PINS;
	localparam int F_LO   = M_LO + `NUM_BUFS;
	localparam int S_LO   = F_LO + `NUM_BUFS;
	localparam int E_LO   = S_LO + `NUM_BUFS;
	localparam int SYNC_W = E_LO + `NUM_BUFS;
	localparam logic [`NUM_QUADS-1:0] LEFT_MASK = `QUAD_LEFT_MASK;

	logic [SYNC_W-1:0]           raw_in;
	logic [SYNC_W-1:0]           sync_out;
	logic [`NUM_GLOBAL_PINS-1:0] g_s;
	logic [`NUM_HALF_PINS-1:0]   l_s;
	logic [`NUM_HALF_PINS-1:0]   r_s;
	logic [`NUM_BUFS-1:0]        m_s;
	logic [`NUM_BUFS-1:0]        f_s;
	logic [`NUM_BUFS-1:0]        sel_s;
	logic [`NUM_BUFS-1:0]        en_s;
	logic [31:0]                 pin_s;
	logic [`NUM_BUFS-1:0]        line_clk;
	logic [`NUM_BUFS-1:0]        buf_sel_eff;
	logic [`NUM_BUFS-1:0]        buf_en_eff;
	logic [`NUM_BUFS-1:0]        buf_clk;
	logic [`NUM_BUFS-1:0]        buf_src;
	logic [`NUM_BUFS-1:0]        buf_run;
	logic [`NUM_QUADS-1:0][`QUAD_WIDTH-1:0] quad_nxt;

	// Switch matrix choice for one line; absent manager reads low
	function automatic logic line_source(
		input src_sel_t src,
		input logic     pin,
		input logic     pin_alt,
		input logic     mgr,
		input logic     fab,
		input logic     mgr_ok
	);
		logic pick;
		pick = 1'b0;
		unique case (src)
			SRC_PIN:     pick = pin;
			SRC_PIN_ALT: pick = pin_alt;
			SRC_MANAGER: pick = mgr & mgr_ok;
			SRC_FABRIC:  pick = fab;
		endcase
		return pick;
	endfunction : line_source

	// Flavour to {enable, select}; an illegal flavour parks the buffer
	// Plain forces the first input with a constant enable
	function automatic logic [1:0] mode_decode(
		input buf_mode_t mode,
		input logic      sel,
		input logic      en
	);
		logic [1:0] eff;
		eff = 2'h0;
		unique case (mode)
			MODE_SELECT: eff = {1'b1, sel};
			MODE_PLAIN:  eff = 2'h2;
			MODE_GATED:  eff = {en, 1'b0};
			default:     eff = 2'h0;
		endcase
		return eff;
	endfunction : mode_decode

	// Every clock, select and enable crosses into clk before use
	// Field order must match the offsets above
	assign raw_in = {buf_enable,
		buf_select,
		fabric_clk,
		clock_manager_tile_clk,
		right_half_clock_pin,
		left_half_clock_pin,
		global_clock_pin};

	// Select moves at any time; only sampling jitter is left, no runt
	clock_level_sync #(
		.WIDTH     (SYNC_W)
	) u_sync (
		.clk       (clk),
		.srst      (srst),
		.async_in  (raw_in),
		.level_out (sync_out)
	);

	// Select and enable reach the buffers only through both flops
	AST_SYNC_SELECT: assert property (@(posedge clk) disable iff (srst)
		(!$past(srst) && !$past(srst, 2))
		|-> {en_s, sel_s} == $past({buf_enable, buf_select}, 2))
		else $error("select or enable bypassed the synchroniser");

	// Unpack synchronised levels
	assign g_s   = sync_out[G_LO +: `NUM_GLOBAL_PINS];
	assign l_s   = sync_out[L_LO +: `NUM_HALF_PINS];
	assign r_s   = sync_out[R_LO +: `NUM_HALF_PINS];
	assign m_s   = sync_out[M_LO +: `NUM_BUFS];
	assign f_s   = sync_out[F_LO +: `NUM_BUFS];
	assign sel_s = sync_out[S_LO +: `NUM_BUFS];
	assign en_s  = sync_out[E_LO +: `NUM_BUFS];
	assign pin_s = {r_s, l_s, g_s};

	// One matrix line and one buffer per index; pairs cross their inputs
	for (genvar b = 0; b < `NUM_BUFS; b++) begin : g_buf
		localparam int PEER = b ^ 1;
		wire logic pin_a;
		wire logic pin_b;
		wire logic mgr_ok;

		// Half edges have one pin per line, so the alternate repeats it
		if (b < `LEFT_BASE) begin : g_global
			assign pin_a  = g_s[2*b];
			assign pin_b  = g_s[2*b+1];
			assign mgr_ok = 1'b1;
		end else if (b < `RIGHT_BASE) begin : g_left
			assign pin_a  = l_s[b-`LEFT_BASE];
			assign pin_b  = l_s[b-`LEFT_BASE];
			assign mgr_ok = LR_MANAGER_PRESENT;
		end else begin : g_right
			assign pin_a  = r_s[b-`RIGHT_BASE];
			assign pin_b  = r_s[b-`RIGHT_BASE];
			assign mgr_ok = LR_MANAGER_PRESENT;
		end

		// Line choice, then flavour to effective select and enable
		assign line_clk[b] = line_source(line_src[b], pin_a, pin_b, m_s[b], f_s[b], mgr_ok);
		assign {buf_en_eff[b], buf_sel_eff[b]} = mode_decode(buf_mode[b], sel_s[b], en_s[b]);

		// Own line on first input, partner's line on second
		glitchless_clock_select_buffer u_buf (
			.clk             (clk),
			.srst            (srst),
			.clock_in_first  (line_clk[b]),
			.clock_in_second (line_clk[PEER]),
			.select          (buf_sel_eff[b]),
			.enable          (buf_en_eff[b]),
			.clock_out_r     (buf_clk[b]),
			.source_r        (buf_src[b]),
			.running         (buf_run[b])
		);

		// Matrix and flavour checks for this buffer
		AST_NO_MANAGER: assert property (@(posedge clk) disable iff (srst)
			(line_src[b] == SRC_MANAGER) |-> line_clk[b] == (m_s[b] && mgr_ok))
			else $error("manager line ignores its tile or its presence");
		AST_PLAIN_FORWARD: assert property (@(posedge clk) disable iff (srst)
			(buf_mode[b] == MODE_PLAIN && buf_run[b] && !buf_src[b])
			|=> buf_clk[b] == $past(line_clk[b]))
			else $error("plain driver does not forward its line");
		AST_BAD_MODE_PARK: assert property (@(posedge clk) disable iff (srst)
			(!(buf_mode[b] inside {MODE_SELECT, MODE_PLAIN, MODE_GATED}) && !buf_run[b])
			|=> !buf_run[b] && !buf_clk[b])
			else $error("buffer with an illegal flavour left park");
		AST_GATED_HOLD: assert property (@(posedge clk) disable iff (srst)
			(buf_mode[b] == MODE_GATED && !en_s[b] && !buf_run[b]) |=> !buf_run[b])
			else $error("gated driver ran while disabled");

		// One check per pair; each pair is fed by one matrix
		if ((b % 2) == 0) begin : g_pair
			AST_PAIR_SHARE: assert property (@(posedge clk) disable iff (srst)
				(buf_run[b] && buf_run[PEER] && !buf_src[b] && buf_src[PEER]
				&& $past(buf_run[b]) && $past(buf_run[PEER])
				&& $past(!buf_src[b]) && $past(buf_src[PEER]))
				|-> buf_clk[b] == buf_clk[PEER])
				else $error("paired buffers disagree on a shared line");
			COV_PAIR_CROSS: cover property (@(posedge clk) disable iff (srst)
				buf_run[b] && buf_run[PEER] && !buf_src[b] && buf_src[PEER]);
		end
	end

	// Quadrant fan-out: globals everywhere, half buffers on their side
	// No per-quadrant gating: every quadrant of a half sees the same clocks
	for (genvar q = 0; q < `NUM_QUADS; q++) begin : g_quad
		assign quad_nxt[q] = {LEFT_MASK[q] ? buf_clk[`LEFT_BASE +: `NUM_HALF_BUFS]
			: buf_clk[`RIGHT_BASE +: `NUM_HALF_BUFS],
			buf_clk[`TOP_BASE +: `NUM_GLOBAL_BUFS]};

		// Each quadrant repeats the registered buffer levels
		AST_GLOBAL_ALL: assert property (@(posedge clk) disable iff (srst)
			quad_clk_r[q][`NUM_GLOBAL_BUFS-1:0] == $past(buf_clk[`NUM_GLOBAL_BUFS-1:0]))
			else $error("global buffers missing from a quadrant");

		AST_QUAD_MATCH: assert property (@(posedge clk) disable iff (srst)
			quad_clk_r[q][`NUM_GLOBAL_BUFS-1:0] == quad_clk_r[0][`NUM_GLOBAL_BUFS-1:0])
			else $error("quadrants disagree on a global clock");

		AST_HALF_TWIN: assert property (@(posedge clk) disable iff (srst)
			quad_clk_r[q][`QUAD_WIDTH-1:`NUM_GLOBAL_BUFS]
			== quad_clk_r[q ^ 1][`QUAD_WIDTH-1:`NUM_GLOBAL_BUFS])
			else $error("two quadrants of one half disagree");

		if (LEFT_MASK[q]) begin : g_left_q
			AST_HALF_LEFT: assert property (@(posedge clk) disable iff (srst)
				quad_clk_r[q][`QUAD_WIDTH-1:`NUM_GLOBAL_BUFS]
				== $past(buf_clk[`LEFT_BASE +: `NUM_HALF_BUFS]))
				else $error("left quadrant not fed by left buffers");
		end else begin : g_right_q
			AST_HALF_RIGHT: assert property (@(posedge clk) disable iff (srst)
				quad_clk_r[q][`QUAD_WIDTH-1:`NUM_GLOBAL_BUFS]
				== $past(buf_clk[`RIGHT_BASE +: `NUM_HALF_BUFS]))
				else $error("right quadrant not fed by right buffers");
		end
	end

	// Output stage; one extra cycle keeps every output on a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			quad_clk_r   <= '0;
			buf_clk_r    <= '0;
			buf_source_r <= '0;
		end else begin
			quad_clk_r   <= quad_nxt;
			buf_clk_r    <= buf_clk;
			buf_source_r <= buf_src;
		end
	end

	// Registered copies trail the buffers by exactly one edge
	AST_OUT_REG: assert property (@(posedge clk) disable iff (srst)
		{buf_clk_r, buf_source_r} == $past({buf_clk, buf_src}))
		else $error("buffer outputs not registered faithfully");

	// Pin copies; the feed is a static path enable, so it is not synchronised
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_user_r    <= '0;
			pin_manager_r <= '0;
		end else begin
			pin_user_r    <= pin_s;
			pin_manager_r <= pin_s & pin_manager_feed;
		end
	end

	// Pin paths: three edges from pin to user copy
	AST_PIN_USER: assert property (@(posedge clk) disable iff (srst)
		(!$past(srst) && !$past(srst, 2) && !$past(srst, 3))
		|-> pin_user_r == $past({right_half_clock_pin, left_half_clock_pin,
		global_clock_pin}, 3))
		else $error("user pin level lost");
	AST_PIN_MANAGER: assert property (@(posedge clk) disable iff (srst)
		pin_manager_r == (pin_user_r & $past(pin_manager_feed)))
		else $error("manager feed does not match pin and path enable");

	// A low pin must never show high on the manager path
	AST_PIN_FEED_GATE: assert property (@(posedge clk) disable iff (srst)
		(pin_manager_r & ~pin_user_r) == 32'h0)
		else $error("manager path high on a low pin");

	// Scenarios worth seeing: a global edge and a right-half edge
	COV_QUAD_RISE: cover property (@(posedge clk) disable iff (srst) $rose(quad_clk_r[0][0]));
	COV_HALF_RISE: cover property (@(posedge clk) disable iff (srst) $rose(quad_clk_r[3][8]));

endmodule : glitchless_clock_mux_network
`default_nettype wire

// *** core/clock_network_map.svh ***
// Constants of the global clock distribution network.
// Assumes inclusion by bare name from the network top and the bench.
`ifndef CLOCK_NETWORK_MAP_SVH
`define CLOCK_NETWORK_MAP_SVH

// Dedicated clock input pins per edge group
`define NUM_GLOBAL_PINS 16
`define NUM_HALF_PINS   8

// Buffer population and index bases
`define NUM_BUFS        24
`define NUM_GLOBAL_BUFS 8
`define NUM_HALF_BUFS   8
`define TOP_BASE        0
`define BOTTOM_BASE     4
`define LEFT_BASE       8
`define RIGHT_BASE      16

// Quadrants: bit set marks a left-half quadrant
`define NUM_QUADS       4
`define QUAD_LEFT_MASK  4'h3
`define QUAD_WIDTH      16

// Synchroniser depth
`define SYNC_STAGES     2

`endif

// *** core/clock_network_pkg.sv ***
// Types shared by the clock network and its select buffers.
// Assumes compilation before every module that imports it.
package clock_network_pkg;

	// Source picked by one switch matrix line
	typedef enum logic [1:0] {SRC_PIN, SRC_PIN_ALT, SRC_MANAGER, SRC_FABRIC} src_sel_t;

	// Buffer flavour: select, plain driver or gated driver
	typedef enum logic [1:0] {MODE_SELECT, MODE_PLAIN, MODE_GATED} buf_mode_t;

	// Select buffer state
	typedef enum logic {ST_PARK, ST_RUN} buf_state_t;

endpackage : clock_network_pkg

// *** core/clock_level_sync.sv ***
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is unrelated to clk; bits are not coherent as a word.
`timescale 1ns/1ps
`default_nettype none
module clock_level_sync #(
	parameter int WIDTH = 8               // Number of levels
) (
	input  wire logic             clk,       // Sampling clock
	input  wire logic             srst,      // Synchronous reset, high
	input  wire logic [WIDTH-1:0] async_in,  // Raw levels
	output logic      [WIDTH-1:0] level_out  // Synchronised levels
);

	logic [WIDTH-1:0] stage1_r;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			stage1_r  <= '0;
			level_out <= '0;
		end else begin
			stage1_r  <= async_in;
			level_out <= stage1_r;
		end
	end

endmodule : clock_level_sync
`default_nettype wire

// *** core/glitchless_clock_select_buffer.sv ***
// One glitch-free 2-to-1 clock select buffer, oversampled by clk.
// Assumes clock inputs, select and enable are already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module glitchless_clock_select_buffer
	import clock_network_pkg::*;
(
	input  wire logic clk,             // Sampling clock
	input  wire logic srst,            // Synchronous reset, high
	input  wire logic clock_in_first,  // First clock level
	input  wire logic clock_in_second, // Second clock level
	input  wire logic select,          // Source request, 1 picks second
	input  wire logic enable,          // Output enable
	output logic      clock_out_r,     // Buffered clock
	output logic      source_r,        // Source now driving the output
	output logic      running          // High while a source drives
);

	buf_state_t state_r;
	buf_state_t state_nxt;
	logic       src_nxt;
	logic       out_nxt;
	logic       prev_first_r;
	logic       prev_second_r;
	wire logic  cur_clk;
	wire logic  new_clk;
	wire logic  new_prev;
	wire logic  new_fall;
	wire logic  want_change;

	// Live source, requested source and its fall; whole new low phase ahead
	assign cur_clk     = source_r ? clock_in_second : clock_in_first;
	assign new_clk     = select ? clock_in_second : clock_in_first;
	assign new_prev    = select ? prev_second_r : prev_first_r;
	assign new_fall    = new_prev & ~new_clk;
	assign want_change = ~enable | (select != source_r);
	assign running     = (state_r == ST_RUN);

	// Release old source only while low; take new one at its fall
	always_comb begin
		state_nxt = state_r;
		src_nxt   = source_r;
		out_nxt   = 1'b0;
		unique case (state_r)
			ST_RUN: begin
				out_nxt = cur_clk;
				if (want_change && !cur_clk) begin
					state_nxt = ST_PARK;
				end
			end
			ST_PARK: begin
				if (enable && new_fall) begin
					state_nxt = ST_RUN;
					src_nxt   = select;
				end
			end
		endcase
	end

	// Each input tracked alone, no phase relation assumed
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r       <= ST_PARK;
			source_r      <= 1'b0;
			clock_out_r   <= 1'b0;
			prev_first_r  <= 1'b0;
			prev_second_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			source_r      <= src_nxt;
			clock_out_r   <= out_nxt;
			prev_first_r  <= clock_in_first;
			prev_second_r <= clock_in_second;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_FOLLOW_FIRST: assert property (
		(state_r == ST_RUN && !source_r) |=> clock_out_r == $past(clock_in_first))
		else $error("output does not follow the first input");
	AST_FOLLOW_SECOND: assert property (
		(state_r == ST_RUN && source_r) |=> clock_out_r == $past(clock_in_second))
		else $error("output does not follow the second input");
	AST_PARK_LOW: assert property (
		(state_r == ST_PARK) |-> !clock_out_r)
		else $error("output high while parked");
	AST_RISE_FROM_SOURCE: assert property (
		$rose(clock_out_r) |-> $past(state_r == ST_RUN) && $past(cur_clk))
		else $error("output rose without its source rising");
	AST_HANDOVER_LOW: assert property (
		$changed(source_r) |-> !clock_out_r && $past(state_r == ST_PARK) && $past(new_fall))
		else $error("source changed outside a low phase");
	AST_GATE_OFF: assert property (
		(!enable && state_r == ST_RUN && !cur_clk) |=> state_r == ST_PARK)
		else $error("disabled buffer kept running");

	COV_SWITCH: cover property ($changed(source_r));
	COV_REGATE: cover property ((state_r == ST_PARK && !enable) ##1 enable ##[1:50] running);

endmodule : glitchless_clock_select_buffer
`default_nettype wire

// *** sim/clock_source_model.sv ***
// Far side of the clock network: free-running pin, manager and fabric clocks.
// Assumes clk is the bench sampling clock; levels move 1 ns after its edge.
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
	input  wire logic        clk,  // Bench sampling clock
	input  wire logic        hold, // Freeze every level
	output logic      [15:0] gpin, // Top and bottom pins
	output logic      [7:0]  lpin, // Left edge pins
	output logic      [7:0]  rpin, // Right edge pins
	output logic      [23:0] mgr,  // Manager tile clocks
	output logic      [23:0] fab   // Fabric double lines
);
	logic [79:0] lvl_r;
	int          cnt [80];

	// Staggered start over five offsets; sources 45 apart share a phase
	initial begin
		lvl_r = 80'h0;
		foreach (cnt[i]) cnt[i] = i % 5;
	end

	// Half periods of 4 to 12 cycles, unrelated to each other
	always @(posedge clk) begin
		#1;
		if (!hold) begin
			for (int i = 0; i < 80; i++) begin
				cnt[i] = cnt[i] + 1;
				if (cnt[i] >= 4 + (i * 7) % 9) begin
					cnt[i] = 0;
					lvl_r[i] = ~lvl_r[i];
				end
			end
		end
	end

	// Frozen levels let the bench compare without chasing latency
	assign {fab, mgr, rpin, lpin, gpin} = lvl_r;
endmodule : clock_source_model
`default_nettype wire

// *** sim/glitchless_clock_mux_network_tb_top.sv ***
// Self-checking bench for the global clock network.
// Assumes the model drives every clock; the bench drives selects and modes.
`timescale 1ns/1ps
`default_nettype none
`include "clock_network_map.svh"
module glitchless_clock_mux_network_tb_top
	import clock_network_pkg::*;
;
	logic                                  clk;
	logic                                  srst;
	logic                                  hold;
	logic [15:0]                           gpin;
	logic [7:0]                            lpin;
	logic [7:0]                            rpin;
	logic [23:0]                           mgr;
	logic [23:0]                           fab;
	logic [23:0]                           buf_select;
	logic [23:0]                           buf_enable;
	src_sel_t                              line_src [`NUM_BUFS];
	buf_mode_t                             buf_mode [`NUM_BUFS];
	logic [31:0]                           pin_manager_feed;
	logic [`NUM_QUADS-1:0][`QUAD_WIDTH-1:0] quad_clk_r;
	logic [23:0]                           buf_clk_r;
	logic [23:0]                           buf_source_r;
	logic [31:0]                           pin_user_r;
	logic [31:0]                           pin_manager_r;
	int                                    miscompares;
	int                                    total_checks;
	logic                                  mon;
	logic                                  mon_last;
	logic                                  mon_seen;
	int                                    mon_run;
	int                                    min_run;

	clock_source_model u_src (.clk(clk), .hold(hold), .gpin(gpin), .lpin(lpin),
		.rpin(rpin), .mgr(mgr), .fab(fab));

	glitchless_clock_mux_network u_dut (.clk(clk), .srst(srst), .global_clock_pin(gpin),
		.left_half_clock_pin(lpin), .right_half_clock_pin(rpin),
		.clock_manager_tile_clk(mgr), .fabric_clk(fab), .buf_select(buf_select),
		.buf_enable(buf_enable), .line_src(line_src), .buf_mode(buf_mode),
		.pin_manager_feed(pin_manager_feed), .quad_clk_r(quad_clk_r),
		.buf_clk_r(buf_clk_r), .buf_source_r(buf_source_r),
		.pin_user_r(pin_user_r), .pin_manager_r(pin_manager_r));

	// 200 MHz sampling clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Shortest complete run of buffer 0 output, partial runs ignored
	always @(posedge clk) begin
		if (mon) begin
			if (buf_clk_r[0] !== mon_last) begin
				if (mon_seen && mon_run < min_run) min_run = mon_run;
				mon_seen = 1'b1;
				mon_run = 1;
			end else begin
				mon_run++;
			end
			mon_last = buf_clk_r[0];
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test

	// Expected level of a switch matrix line, from the source choice
	function automatic logic line_lvl(input int b);
		case (line_src[b])
			SRC_MANAGER: return mgr[b];
			SRC_FABRIC:  return fab[b];
			default: begin
				if (b < 8) return (line_src[b] == SRC_PIN_ALT) ? gpin[2*b+1] : gpin[2*b];
				else if (b < 16) return lpin[b-8];
				else return rpin[b-16];
			end
		endcase
	endfunction : line_lvl

	// Freeze until the pair's lines differ, then compare the buffer and quadrants
	task automatic settle_check(input int b, input logic second);
		logic want;
		int   k;
		for (k = 0; k < 20; k++) begin
			hold = 1'b1;
			step(8);
			if (line_lvl(b) !== line_lvl(b ^ 1)) break;
			hold = 1'b0;
			step(3);
		end
		if (k == 20) begin
			miscompares++;
			finish_test();
		end
		want = second ? line_lvl(b ^ 1) : line_lvl(b);
		check(buf_clk_r[b], want);
		check(buf_source_r[b], second);
		if (b < 16) check(quad_clk_r[0][b], want);
		if (b < 16) check(quad_clk_r[1][b], want);
		if (b < 8 || b >= 16) check(quad_clk_r[2][(b < 8) ? b : b - 8], want);
		if (b < 8 || b >= 16) check(quad_clk_r[3][(b < 8) ? b : b - 8], want);
		hold = 1'b0;
		step(1);
	endtask : settle_check

	// Both select values on top, pair partner, left and right buffers
	task automatic t_select();
		int bl [4] = '{0, 1, 9, 17};
		foreach (bl[i]) begin
			buf_select[bl[i]] = 1'b0;
			step(60);
			settle_check(bl[i], 1'b0);
			buf_select[bl[i]] = 1'b1;
			step(60);
			settle_check(bl[i], 1'b1);
		end
	endtask : t_select

	// Repeated switches between unrelated clocks: no runt phases
	task automatic t_glitch();
		min_run = 1000;
		mon_seen = 1'b0;
		mon_last = buf_clk_r[0];
		mon = 1'b1;
		for (int i = 0; i < 8; i++) begin
			buf_select[0] = ~buf_select[0];
			step(23 + i * 5);
		end
		mon = 1'b0;
		check(min_run >= 4, 1'b1);
		check(mon_seen, 1'b1);
	endtask : t_glitch

	// Plain driver ignores select; gated driver holds low while disabled
	task automatic t_variants();
		int hi;
		int off;
		buf_mode[2] = MODE_PLAIN;
		buf_select[2] = 1'b1;
		step(60);
		settle_check(2, 1'b0);
		buf_mode[4] = MODE_GATED;
		buf_mode[10] = buf_mode_t'(2'h3); // Illegal flavour must park low
		buf_select[4] = 1'b1;
		buf_enable[4] = 1'b0;
		step(60);
		hi = 0;
		off = 0;
		for (int i = 0; i < 40; i++) begin
			if (buf_clk_r[4] !== 1'b0) hi++;
			if (buf_clk_r[10] !== 1'b0) off++;
			step(1);
		end
		check(hi, 0);
		check(off, 0);
		buf_enable[4] = 1'b1;
		step(60);
		settle_check(4, 1'b0);
	endtask : t_variants

	// Every line source code on one buffer
	task automatic t_sources();
		for (int s = 0; s < 4; s++) begin
			line_src[6] = src_sel_t'(s);
			step(60);
			settle_check(6, 1'b0);
		end
		line_src[6] = SRC_PIN;
	endtask : t_sources

	// Pins as user inputs and through the manager path
	task automatic t_pins();
		hold = 1'b1;
		pin_manager_feed = 32'ha5c3_0ff0;
		step(8);
		check(pin_user_r, {rpin, lpin, gpin});
		check(pin_manager_r, {rpin, lpin, gpin} & pin_manager_feed);
		hold = 1'b0;
		step(1);
	endtask : t_pins

	initial begin
		srst = 1'b1;
		hold = 1'b0;
		mon = 1'b0;
		mon_last = 1'b0;
		mon_seen = 1'b0;
		mon_run = 0;
		min_run = 1000;
		miscompares = 0;
		total_checks = 0;
		buf_select = 24'h0;
		buf_enable = 24'hff_ffff;
		pin_manager_feed = 32'h0;
		foreach (line_src[i]) line_src[i] = SRC_PIN;
		foreach (buf_mode[i]) buf_mode[i] = MODE_SELECT;
		step(10);
		check(buf_clk_r, 24'h0);
		check(buf_source_r, 24'h0);
		srst = 1'b0;
		t_select();
		t_glitch();
		t_variants();
		t_sources();
		t_pins();
		finish_test();
	end
endmodule : glitchless_clock_mux_network_tb_top
`default_nettype wire
